// [core/tmr_core.sv]
/*
  Sixteen-bit timer/counter with capture, up/down auto-reload, baud clock
  generation for the serial port and a 50% duty clock output.
  Assumes sys_clk is the oscillator, the register bus runs on sys_clk, and the
  trigger input and external count pin arrive asynchronously from pins.
*/
`timescale 1ns/1ps
module tmr_core
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Special function register bus
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWr,
  input  wire logic [7:0] sfrWdata,
  input  wire logic       sfrRd,
  output logic      [7:0] sfrRdata,
  // Trigger input pin
  input  wire logic       triggerInput,
  // External count pin as three signals
  input  wire logic       countPinIn,
  output logic            countPinOut,
  output logic            countPinOe,
  // Serial port clocks and interrupt
  input  wire logic       timer1Ovf,
  output logic            rxBaudClk,
  output logic            txBaudClk,
  output logic            timerIrq
);
  import tmr_pkg::*;

  // All timer state in one record
  typedef struct packed {
    logic        trigMeta;   // Trigger synchroniser, first stage
    logic        trigSync;   // Trigger synchroniser, second stage
    logic        trigPrev;   // Previous trigger sample for edge detect
    logic        pinMeta;    // Count pin synchroniser, first stage
    logic        pinSync;    // Count pin synchroniser, second stage
    logic        pinPrev;    // Previous count pin sample
    logic [3:0]  pre;        // Oscillator prescaler
    logic [15:0] cnt;        // counter_high:counter_low
    logic [15:0] cap;        // capture_high:capture_low
    logic [7:0]  ctrl;       // timer_control
    logic [1:0]  mode;       // timer_mode_register bits 1..0
    logic        clkOut;     // Clock output level
    logic        baudTick;   // One-cycle overflow pulse to the serial port
    logic [7:0]  rdata;      // Registered read data
  } tmr_state_t;

  tmr_state_t stQ;           // Registered state
  tmr_state_t stD;           // Next state
  logic [1:0] rstPipe;       // Reset release synchroniser
  logic       rstSync;       // Synchronised active-low reset

  // Falling edge between two successive samples
  function automatic logic fallEdge(input logic prev, input logic cur);
    fallEdge = prev & ~cur;
  endfunction : fallEdge

  // Next counter value one step up, wrapping at sixteen bits
  function automatic logic [15:0] stepUp(input logic [15:0] v);
    stepUp = 16'(v + 16'h1);
  endfunction : stepUp

  // Decoded mode bits
  logic runOn;               // Run control
  logic extTrigEn;           // External trigger enable
  logic ctSel;               // 1 = count external pin
  logic baudMode;            // Either serial clock select set
  logic clkOutMode;          // Clock output enabled in timer mode
  logic fastMode;            // Counts at osc/2
  logic capMode;             // Capture mode, not overridden
  logic downEn;              // Up/down counter mode
  logic countDown;           // Current direction is down
  logic trigFall;            // Synchronised trigger falling edge
  logic pinFall;             // Synchronised count pin falling edge
  logic countTick;           // Counter advances this cycle
  logic atTop;               // Counter at ffff
  logic atFloor;             // Counter equals capture value
  logic rollUp;              // Upward rollover this cycle
  logic underflow;           // Downward underflow this cycle
  logic trigEvent;           // Enabled trigger edge
  logic ctrlWrite;           // Software write to timer_control

  // Mode decoding; baud and clock-out override capture and up/down
  always_comb begin
    runOn      = stQ.ctrl[BIT_RUN_CONTROL];
    extTrigEn  = stQ.ctrl[BIT_EXT_TRIG_EN];
    ctSel      = stQ.ctrl[BIT_TIMER_CNT_SEL];
    baudMode   = stQ.ctrl[BIT_RX_CLOCK_SEL] | stQ.ctrl[BIT_TX_CLOCK_SEL];
    clkOutMode = stQ.mode[BIT_CLOCK_OUT_EN] & ~ctSel;
    // Baud and clock-out both count state times; that shares the rate
    fastMode   = baudMode | clkOutMode;
    capMode    = stQ.ctrl[BIT_CAP_RELOAD_SEL] & ~fastMode;
    downEn     = stQ.mode[BIT_DOWN_COUNT_EN] & ~fastMode & ~capMode;
    countDown  = downEn & ~stQ.trigSync;
    trigFall   = fallEdge(stQ.trigPrev, stQ.trigSync);
    pinFall    = fallEdge(stQ.pinPrev, stQ.pinSync);
    // Timer source is the prescaler, counter source the pin edges
    if (ctSel) begin
      countTick = runOn & pinFall;
    end else if (fastMode) begin
      countTick = runOn & stQ.pre[0];
    end else begin
      countTick = runOn & (stQ.pre == PRE_LAST);
    end
    atTop      = stQ.cnt == COUNT_TOP;
    atFloor    = stQ.cnt == stQ.cap;
    rollUp     = countTick & ~countDown & atTop;
    underflow  = countTick & countDown & atFloor;
    // In up/down mode the trigger is a direction level, not an event
    trigEvent  = extTrigEn & trigFall & ~downEn;
    ctrlWrite  = sfrWr & (sfrAddr == ADDR_TIMER_CONTROL);
  end

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  // Next-state logic; hardware updates win over software writes
  always_comb begin
    stD          = stQ;
    stD.baudTick = 1'b0;
    // Pin synchronisers; first stage feeds only the second
    stD.trigMeta = triggerInput;
    stD.trigSync = stQ.trigMeta;
    stD.trigPrev = stQ.trigSync;
    stD.pinMeta  = countPinIn;
    stD.pinSync  = stQ.pinMeta;
    stD.pinPrev  = stQ.pinSync;
    // Prescaler runs freely so the machine cycle rate is fixed
    stD.pre = (stQ.pre == PRE_LAST) ? 4'h0 : 4'(stQ.pre + 4'h1);

    // Software writes first
    if (sfrWr) begin
      case (sfrAddr)
        ADDR_TIMER_CONTROL: stD.ctrl      = sfrWdata;
        ADDR_TIMER_MODE:    stD.mode      = sfrWdata[1:0];
        ADDR_CAPTURE_LOW:   stD.cap[7:0]  = sfrWdata;
        ADDR_CAPTURE_HIGH:  stD.cap[15:8] = sfrWdata;
        ADDR_COUNTER_LOW:   stD.cnt[7:0]  = sfrWdata;
        ADDR_COUNTER_HIGH:  stD.cnt[15:8] = sfrWdata;
        default:            stD.rdata     = stQ.rdata;
      endcase
    end

    // Counting; capture mode free-runs, every other mode reloads on rollover.
    // A software write to the counter loses against a tick in the same cycle,
    // which is why the timer should be stopped before it is written
    if (countTick) begin
      if (capMode) begin
        // Free-running, no reload even on capture
        stD.cnt = stepUp(stQ.cnt);
        if (atTop) begin
          stD.ctrl[BIT_OVERFLOW_FLAG] = 1'b1;
        end
      end else if (countDown) begin
        if (atFloor) begin
          stD.cnt = COUNT_TOP;
          stD.ctrl[BIT_OVERFLOW_FLAG] = 1'b1;
        end else begin
          stD.cnt = 16'(stQ.cnt - 16'h1);
        end
      end else if (atTop) begin
        stD.cnt = stQ.cap;
        if (fastMode) begin
          // Rollover only drives the serial clock and the clock pin
          stD.baudTick = baudMode;
          if (clkOutMode) begin
            stD.clkOut = ~stQ.clkOut;
          end
        end else begin
          stD.ctrl[BIT_OVERFLOW_FLAG] = 1'b1;
        end
      end else begin
        stD.cnt = stepUp(stQ.cnt);
      end
    end

    // Seventeenth count bit in up/down mode
    if (downEn && (underflow || rollUp)) begin
      stD.ctrl[BIT_EXT_EVENT_FLAG] = ~stD.ctrl[BIT_EXT_EVENT_FLAG];
    end

    // Trigger edge events
    // An edge that meets an up rollover keeps the rollover reload; both load the same value
    if (trigEvent) begin
      stD.ctrl[BIT_EXT_EVENT_FLAG] = 1'b1;
      if (baudMode) begin
        stD.ctrl[BIT_EXT_EVENT_FLAG] = 1'b1;
      end else if (capMode) begin
        stD.cap = stQ.cnt;
      end else if (!rollUp) begin
        stD.cnt = stQ.cap;
      end
    end

    // Registered read data; reserved bits read zero
    if (sfrRd) begin
      case (sfrAddr)
        ADDR_TIMER_CONTROL: stD.rdata = stQ.ctrl;
        ADDR_TIMER_MODE:    stD.rdata = {6'h00, stQ.mode};
        ADDR_CAPTURE_LOW:   stD.rdata = stQ.cap[7:0];
        ADDR_CAPTURE_HIGH:  stD.rdata = stQ.cap[15:8];
        ADDR_COUNTER_LOW:   stD.rdata = stQ.cnt[7:0];
        ADDR_COUNTER_HIGH:  stD.rdata = stQ.cnt[15:8];
        default:            stD.rdata = 8'h00;
      endcase
    end
  end

  // State register
  // Reset clears the whole record, then loads the named reset values
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      stQ       <= '0;
      stQ.ctrl  <= RST_TIMER_CONTROL;
      stQ.mode  <= RST_TIMER_MODE;
      stQ.cnt   <= RST_COUNTER;
      stQ.cap   <= RST_CAPTURE;
      stQ.pre   <= 4'h0;
    end else begin
      stQ <= stD;
    end
  end

  // Outputs
  // The serial clocks fall back to the other timer's pulse whenever our select is clear
  assign sfrRdata    = stQ.rdata;
  assign countPinOut = stQ.clkOut;
  assign countPinOe  = clkOutMode;
  assign rxBaudClk   = stQ.ctrl[BIT_RX_CLOCK_SEL] ? stQ.baudTick : timer1Ovf;
  assign txBaudClk   = stQ.ctrl[BIT_TX_CLOCK_SEL] ? stQ.baudTick : timer1Ovf;
  // Event flag does not interrupt in up/down mode
  assign timerIrq    = stQ.ctrl[BIT_OVERFLOW_FLAG] |
                       (stQ.ctrl[BIT_EXT_EVENT_FLAG] & ~stQ.mode[BIT_DOWN_COUNT_EN]);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  a_ovf_not_baud: assert property (baudMode && !ctrlWrite |=> !$rose(stQ.ctrl[BIT_OVERFLOW_FLAG]))
    else $error("overflow flag set while serial clock selected");
  a_ovf_sticky: assert property (stQ.ctrl[BIT_OVERFLOW_FLAG] && !ctrlWrite |=> stQ.ctrl[BIT_OVERFLOW_FLAG])
    else $error("overflow flag cleared by hardware");
  a_run_stops: assert property (!runOn && !sfrWr |=> $stable(stQ.cnt))
    else $error("counter moved with run control clear");
  a_timer_rate: assert property (countTick && !ctSel && !fastMode |-> stQ.pre == PRE_LAST)
    else $error("timer tick off machine cycle");
  a_baud_rate: assert property (runOn && fastMode && !ctSel && !sfrWr |=> countTick != $past(countTick))
    else $error("state time tick not every second cycle");
  a_up_reload: assert property (rollUp && !fastMode && !capMode && !sfrWr
                                |=> stQ.cnt == $past(stQ.cap) && stQ.ctrl[BIT_OVERFLOW_FLAG])
    else $error("overflow did not reload");
  a_down_under: assert property (underflow && !sfrWr && !trigEvent
                                 |=> stQ.cnt == COUNT_TOP && stQ.ctrl[BIT_OVERFLOW_FLAG])
    else $error("underflow did not load top");
  a_cap_copy: assert property (trigEvent && capMode |=> stQ.cap == $past(stQ.cnt)
                               && stQ.ctrl[BIT_EXT_EVENT_FLAG])
    else $error("capture did not copy counter");
  a_cap_norel: assert property (capMode && countTick && !sfrWr |=> stQ.cnt == 16'($past(stQ.cnt) + 16'h1))
    else $error("capture mode counter did not advance");
  a_baud_norel: assert property (baudMode && trigEvent && !countTick && !sfrWr |=> $stable(stQ.cnt))
    else $error("trigger reloaded in baud mode");
  a_clk_toggle: assert property (rollUp && clkOutMode |=> $changed(stQ.clkOut))
    else $error("clock output missed rollover");
  a_irq_down: assert property (stQ.mode[BIT_DOWN_COUNT_EN] && !stQ.ctrl[BIT_OVERFLOW_FLAG] |-> !timerIrq)
    else $error("event flag interrupted in up/down mode");

  // Reload, event flag, seventeenth bit and down step
  a_trig_reload: assert property (trigEvent && !capMode && !baudMode && !sfrWr |=>
                                  stQ.cnt == $past(stQ.cap) && stQ.ctrl[BIT_EXT_EVENT_FLAG])
    else $error("trigger edge did not reload");
  a_baud_flag: assert property (baudMode && trigEvent |=> stQ.ctrl[BIT_EXT_EVENT_FLAG])
    else $error("trigger edge in baud mode set no event flag");
  a_ext_toggle: assert property (downEn && (underflow || rollUp) && !ctrlWrite |=>
                                 $changed(stQ.ctrl[BIT_EXT_EVENT_FLAG]))
    else $error("event flag did not toggle on wrap");
  a_down_step: assert property (countTick && countDown && !atFloor && !sfrWr |=>
                                stQ.cnt == 16'($past(stQ.cnt) - 16'h1))
    else $error("down count did not step");

  // Interrupt and serial clock outputs
  a_irq_set: assert property (stQ.ctrl[BIT_OVERFLOW_FLAG] |-> timerIrq)
    else $error("overflow flag raised no interrupt");
  a_irq_clear: assert property (!stQ.ctrl[BIT_OVERFLOW_FLAG] && !stQ.ctrl[BIT_EXT_EVENT_FLAG] |-> !timerIrq)
    else $error("interrupt with both flags clear");
  a_serial_pass: assert property (!baudMode |-> rxBaudClk == timer1Ovf && txBaudClk == timer1Ovf)
    else $error("serial clock not taken from other timer");
  a_baud_pulse: assert property (stQ.baudTick |=> !stQ.baudTick)
    else $error("baud pulse longer than one cycle");

  // Count sources, capture register and clock pin
  a_pin_count: assert property (countTick && ctSel |-> pinFall)
    else $error("counter mode tick without pin fall");
  a_no_tick_off: assert property (!runOn |-> !countTick)
    else $error("tick with run control clear");
  a_cap_hold: assert property (capMode && !trigEvent && !sfrWr |=> $stable(stQ.cap))
    else $error("capture register moved without a capture");
  a_clk_steady: assert property (!rollUp |=> $stable(stQ.clkOut))
    else $error("clock output moved without rollover");
  a_clkout_noflag: assert property (clkOutMode && !ctrlWrite |=> !$rose(stQ.ctrl[BIT_OVERFLOW_FLAG]))
    else $error("overflow flag set in clock output mode");
  a_pin_owner: assert property (countPinOe |-> !ctSel && stQ.mode[BIT_CLOCK_OUT_EN])
    else $error("count pin driven in counter mode");

  c_capture:  cover property (trigEvent && capMode);
  c_underflow: cover property (underflow);
  c_clock_out: cover property (rollUp && clkOutMode);
  c_baud_tick: cover property (stQ.baudTick);
  c_trig_reload: cover property (trigEvent && !capMode && !baudMode);

endmodule : tmr_core

// [core/tmr_pkg.sv]
/*
  Shared constants for the sixteen-bit capture/reload/clock-out timer:
  register addresses on the special function register bus, control and mode
  bit positions, reset values and prescaler counts.
  Assumes an 8-bit register bus with one-cycle write and read strobes.
*/
package tmr_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8; // timer_control
  localparam logic [7:0] ADDR_TIMER_MODE    = 8'hc9; // timer_mode_register
  localparam logic [7:0] ADDR_CAPTURE_LOW   = 8'hca; // capture_low
  localparam logic [7:0] ADDR_CAPTURE_HIGH  = 8'hcb; // capture_high
  localparam logic [7:0] ADDR_COUNTER_LOW   = 8'hcc; // counter_low
  localparam logic [7:0] ADDR_COUNTER_HIGH  = 8'hcd; // counter_high

  // Bit positions in timer_control
  localparam int BIT_OVERFLOW_FLAG  = 7;
  localparam int BIT_EXT_EVENT_FLAG = 6;
  localparam int BIT_RX_CLOCK_SEL   = 5;
  localparam int BIT_TX_CLOCK_SEL   = 4;
  localparam int BIT_EXT_TRIG_EN    = 3;
  localparam int BIT_RUN_CONTROL    = 2;
  localparam int BIT_TIMER_CNT_SEL  = 1;
  localparam int BIT_CAP_RELOAD_SEL = 0;

  // Bit positions in timer_mode_register; bits 7..2 are reserved and read zero
  localparam int BIT_CLOCK_OUT_EN   = 1;
  localparam int BIT_DOWN_COUNT_EN  = 0;

  // Values after reset, and the counter top value
  localparam logic [7:0]  RST_TIMER_CONTROL = 8'h00;
  localparam logic [1:0]  RST_TIMER_MODE    = 2'h0;
  localparam logic [15:0] RST_COUNTER       = 16'h0000;
  localparam logic [15:0] RST_CAPTURE       = 16'h0000;
  localparam logic [15:0] COUNT_TOP         = 16'hffff;

  // Oscillator periods per machine cycle and per state time
  localparam int         OSC_PER_MACHINE = 12;
  localparam int         OSC_PER_STATE   = 2;
  localparam logic [3:0] PRE_LAST        = 4'(OSC_PER_MACHINE - 1);

endpackage : tmr_pkg

// [sim/tmr_pin_model.sv]
/*
  Pin-side partner of the timer: the trigger input and the external count pin.
  Assumes the bench resolves the count pin from this drive and the timer's enable.
*/
`timescale 1ns/1ps
module tmr_pin_model (
  // Clock
  input  wire logic sys_clk,
  // Pins toward the timer
  output logic      triggerInput,
  output logic      countPinDrive
);
  // Both pins idle at the pull-up level when nobody pulls them low
  initial begin
    triggerInput  = 1'b1;
    countPinDrive = 1'b1;
  end

  // Falling pulses; three cycles each side so the two-flop sampling sees both levels
  task automatic pulse(input bit onTrigger, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (onTrigger) triggerInput <= 1'b0;
      else countPinDrive <= 1'b0;
      repeat (3) @(posedge sys_clk);
      if (onTrigger) triggerInput <= 1'b1;
      else countPinDrive <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask : pulse

  // Static level on the trigger pin, used as count direction
  task automatic set_trigger(input logic lvl);
    @(posedge sys_clk);
    triggerInput <= lvl;
  endtask : set_trigger
endmodule : tmr_pin_model

// [sim/timer2_capture_reload_clockout_tb_top.sv]
/*
  Self-checking bench for the timer: register tasks, a read-result queue and the pin partner.
  Assumes tmr_pkg, tmr_core and tmr_pin_model are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module timer2_capture_reload_clockout_tb_top;
  import tmr_pkg::*;
  // Design stimulus and outputs
  logic        sys_clk, rst_b, sfrWr, sfrRd, timer1Ovf;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata;
  logic        triggerInput, countPinDrive, countPinOut, countPinOe;
  logic        rxBaudClk, txBaudClk, timerIrq;
  wire         countPin = countPinOe ? countPinOut : countPinDrive; // Resolved pin level
  int          n_fail = 0, n_compared = 0, seed;
  logic [15:0] expQ[$];       // Address and expected data of each read
  logic        rdPend = 1'b0; // A read was taken at the last edge
  logic [15:0] note;
  logic [7:0]  capHi;

  tmr_core u_tmr_core (.sys_clk(sys_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrWdata(sfrWdata), .sfrRd(sfrRd), .sfrRdata(sfrRdata), .triggerInput(triggerInput),
    .countPinIn(countPin), .countPinOut(countPinOut), .countPinOe(countPinOe),
    .timer1Ovf(timer1Ovf), .rxBaudClk(rxBaudClk), .txBaudClk(txBaudClk), .timerIrq(timerIrq));
  tmr_pin_model u_tmr_pin_model (.sys_clk(sys_clk), .triggerInput(triggerInput),
    .countPinDrive(countPinDrive));

  // 25 MHz oscillator
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Read data lands one cycle after the read edge; take the oldest note then
  always @(posedge sys_clk) begin
    if (rdPend && expQ.size() > 0) begin
      note = expQ.pop_front();
      `CHK($sformatf("reg %h", note[15:8]), note[7:0], sfrRdata)
    end
    rdPend <= sfrRd;
  end

  // Other timer's overflow pulses, random, so the serial clock path sees traffic
  always @(posedge sys_clk) timer1Ovf <= (($random(seed) & 7) == 0);

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfrAddr  <= a;
    sfrWdata <= d;
    sfrWr    <= 1'b1;
    @(posedge sys_clk);
    sfrWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrRd   <= 1'b1;
    expQ.push_back({a, e});
    @(posedge sys_clk);
    sfrRd <= 1'b0;
  endtask : rd

  // Bounded wait for the interrupt level
  task automatic wait_irq(input int lim);
    int c;
    c = 0;
    while (timerIrq !== 1'b1 && c < lim) begin
      @(posedge sys_clk);
      c++;
    end
    `CHK("timerIrq", 1'b1, timerIrq)
  endtask : wait_irq

  function automatic logic pick(input int s);
    return (s == 0) ? rxBaudClk : (s == 1) ? txBaudClk : countPinOut;
  endfunction : pick

  // Cycles between two rising edges of the chosen output, bounded
  task automatic interval(input int s, input int expv, input string nm);
    int c, t0;
    logic last;
    c = 0;
    t0 = -1;
    last = pick(s);
    while (c < 300) begin
      @(posedge sys_clk);
      c++;
      if (pick(s) && !last && t0 >= 0) break;
      if (pick(s) && !last) t0 = c;
      last = pick(s);
    end
    `CHK(nm, expv, c - t0)
  endtask : interval

  task automatic tend(input string s);
    $display("Test %s done", s);
  endtask : tend

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // Watchdog: the tests need a few hundred cycles; 20000 means a hang
  initial begin
    #(40 * 20000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    seed = 47220;
    {rst_b, sfrWr, sfrRd, timer1Ovf, sfrAddr, sfrWdata} = '0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset values of all registers, plus an unmapped address reading zero
    for (int a = 8'hc7; a <= 8'hcd; a++) rd(8'(a), 8'h00);
    // Serial clocks follow the other timer while both selects are clear
    repeat (16) begin
      @(posedge sys_clk);
      `CHK("rxBaudClk", timer1Ovf, rxBaudClk)
      `CHK("txBaudClk", timer1Ovf, txBaudClk)
    end
    wr(ADDR_TIMER_MODE, 8'hff);
    rd(ADDR_TIMER_MODE, 8'h03);
    wr(ADDR_TIMER_MODE, 8'h00);
    // Stopped counter holds its value
    wr(ADDR_COUNTER_LOW, 8'hfe);
    repeat (40) @(posedge sys_clk);
    rd(ADDR_COUNTER_LOW, 8'hfe);
    tend("reset");
    // Up auto-reload from a random reload value
    capHi = 8'($random(seed));
    wr(ADDR_CAPTURE_LOW, 8'h00);
    wr(ADDR_CAPTURE_HIGH, capHi);
    wr(ADDR_COUNTER_HIGH, 8'hff);
    // Trigger enabled: overflow and trigger edges both reload
    wr(ADDR_TIMER_CONTROL, 8'h0c);
    wait_irq(100);
    rd(ADDR_TIMER_CONTROL, 8'h8c);
    rd(ADDR_COUNTER_HIGH, capHi);
    wr(ADDR_COUNTER_HIGH, capHi ^ 8'h80);
    u_tmr_pin_model.pulse(1'b1, 1);
    rd(ADDR_TIMER_CONTROL, 8'hcc);
    wr(ADDR_TIMER_CONTROL, 8'h80);
    rd(ADDR_COUNTER_HIGH, capHi);
    tend("reload");
    // Capture mode: overflow wraps to zero, then a trigger edge captures
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'hfe);
    wr(ADDR_COUNTER_HIGH, 8'hff);
    wr(ADDR_TIMER_CONTROL, 8'h0d);
    wait_irq(100);
    u_tmr_pin_model.pulse(1'b1, 1);
    repeat (6) @(posedge sys_clk);
    rd(ADDR_TIMER_CONTROL, 8'hcd);
    wr(ADDR_TIMER_CONTROL, 8'hc0);
    rd(ADDR_COUNTER_HIGH, 8'h00);
    rd(ADDR_CAPTURE_HIGH, 8'h00);
    tend("capture");
    // Down count to the capture value, then load of all ones
    wr(ADDR_TIMER_CONTROL, 8'h00);
    u_tmr_pin_model.set_trigger(1'b0);
    wr(ADDR_CAPTURE_LOW, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h03);
    wr(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_TIMER_MODE, 8'h01);
    wr(ADDR_TIMER_CONTROL, 8'h04);
    wait_irq(200);
    rd(ADDR_TIMER_CONTROL, 8'hc4);
    wr(ADDR_TIMER_CONTROL, 8'hc0);
    rd(ADDR_COUNTER_HIGH, 8'hff);
    wr(ADDR_TIMER_MODE, 8'h00);
    u_tmr_pin_model.set_trigger(1'b1);
    tend("down");
    // Counter mode counts pin falls; trigger ignored with its enable clear
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h00);
    wr(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h06);
    u_tmr_pin_model.pulse(1'b0, 5);
    u_tmr_pin_model.pulse(1'b1, 1);
    rd(ADDR_TIMER_CONTROL, 8'h06);
    wr(ADDR_TIMER_CONTROL, 8'h02);
    rd(ADDR_COUNTER_LOW, 8'h05);
    tend("counter");
    // Clock out and both baud clocks from one counter, reload fffc
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(ADDR_CAPTURE_LOW, 8'hfc);
    wr(ADDR_CAPTURE_HIGH, 8'hff);
    wr(ADDR_COUNTER_LOW, 8'hfc);
    wr(ADDR_COUNTER_HIGH, 8'hff);
    wr(ADDR_TIMER_MODE, 8'h02);
    wr(ADDR_TIMER_CONTROL, 8'h3c);
    interval(0, 8, "rx period");
    interval(1, 8, "tx period");
    interval(2, 16, "clock out period");
    `CHK("countPinOe", 1'b1, countPinOe)
    `CHK("timerIrq", 1'b0, timerIrq)
    // Trigger edge in baud mode flags but must not reload
    u_tmr_pin_model.pulse(1'b1, 1);
    rd(ADDR_TIMER_CONTROL, 8'h7c);
    wr(ADDR_TIMER_CONTROL, 8'h30);
    repeat (3) @(posedge sys_clk);
    tend("clock out");
    report_and_stop();
  end
endmodule : timer2_capture_reload_clockout_tb_top
